// ### irm_pkg.sv
// package with register map, field layout, states and timing constants of the modulator
package irm_pkg;

	// derivative register addresses
	localparam logic [2:0] IRM_ADDR_ON_LEN   = 3'h0; // pulse_on_length
	localparam logic [2:0] IRM_ADDR_OFF_LEN  = 3'h1; // pulse_off_length
	localparam logic [2:0] IRM_ADDR_CNT_LOW  = 3'h2; // burst_count_low
	localparam logic [2:0] IRM_ADDR_CTRL     = 3'h3; // modulator_control
	localparam logic [2:0] IRM_ADDR_CNT_HIGH = 3'h4; // burst_count_high

	// modulator_control bit positions
	localparam int IRM_CTRL_WDT_BIT  = 4; // watchdog_reload_strobe, write only
	localparam int IRM_CTRL_RINT_BIT = 3; // interrupt clear, write only
	localparam int IRM_CTRL_PWM_BIT  = 2; // continuous train
	localparam int IRM_CTRL_LGP_BIT  = 1; // long_pulse_enable
	localparam int IRM_CTRL_HF_BIT   = 0; // carrier_modulate_enable

	// widths
	localparam int IRM_CNT_W  = 10; // pulse counter width
	localparam int IRM_CNT_LW = 8;  // low part width

	// reset values
	localparam logic [7:0] IRM_RST_ON_LEN  = 8'h00; // on-time after reset
	localparam logic [7:0] IRM_RST_OFF_LEN = 8'h00; // off-time after reset
	localparam logic [9:0] IRM_RST_CNT     = 10'h000; // pulse counter after reset
	localparam logic [2:0] IRM_RST_CTRL    = 3'h0; // stored mode bits after reset
	localparam logic [7:0] IRM_RST_PORT0   = 8'h00; // port 0 low
	localparam logic [7:0] IRM_RST_PORT1   = 8'hFF; // port 1 high
	localparam logic [3:0] IRM_RST_PORT2   = 4'hF; // port 2 high

	// phase length is register value plus this many oscillator cycles
	localparam logic [8:0] IRM_PHASE_EXTRA = 9'h002;
	// timer counts down to zero, so it is loaded one less than the extra
	localparam logic [8:0] IRM_TIMER_BIAS  = IRM_PHASE_EXTRA - 9'h001;
	// carrier at a quarter of the clock: two cycles active, two idle
	localparam logic [1:0] IRM_CAR_RST     = 2'h0;

	// derivative register operations
	typedef enum logic [1:0]
	{
		IRM_OP_WRITE = 2'h0, // deriv_write_op
		IRM_OP_READ  = 2'h1, // deriv_read_op
		IRM_OP_AND   = 2'h2, // deriv_and_op
		IRM_OP_OR    = 2'h3  // deriv_or_op
	} irm_op_t;

	// one request from the core
	typedef struct packed
	{
		logic       valid; // request strobe
		irm_op_t    op;    // operation
		logic [2:0] addr;  // derivative address
		logic [7:0] data;  // accumulator value
	} irm_req_t;

	// modulator phases, one-hot
	typedef enum logic [2:0]
	{
		IRM_ST_IDLE = 3'b001, // output inactive, no burst
		IRM_ST_ON   = 3'b010, // output active phase
		IRM_ST_OFF  = 3'b100  // gap between pulses
	} irm_state_t;

endpackage : irm_pkg

// ### irm_modulator.sv
// pulse-burst modulator with derivative register port, output pin and port reset levels
`timescale 1ns/1ps
`default_nettype none
module irm_modulator
(
	input  wire logic              core_clk,   // oscillator clock
	input  wire logic              nrst,       // asynchronous reset, active low
	input  wire irm_pkg::irm_req_t req,        // derivative register request
	input  wire logic [2:0]        port_we,    // port latch write strobes 0..2
	input  wire logic [7:0]        port_wdata, // port latch write data
	output var  logic [7:0]        rdata,      // read data, one cycle after request
	output var  logic              mod_out_n,  // modulator pin, active low
	output var  logic              mod_irq,    // modulator ready interrupt flip-flop
	output var  logic              wdt_clear,  // watchdog_reload_strobe pulse
	output var  logic [7:0]        port0,      // port 0 latch
	output var  logic [7:0]        port1,      // port 1 latch
	output var  logic [3:0]        port2       // port 2 latch
);
	import irm_pkg::*;

	logic [7:0]  on_len_q;   // pulse_on_length
	logic [7:0]  off_len_q;  // pulse_off_length
	logic [9:0]  cnt_q;      // pulse counter
	logic [9:0]  cnt_d;      // next pulse counter
	logic [2:0]  ctrl_q;     // stored pwm, lgp, hf
	irm_state_t  state_q;    // modulator phase
	irm_state_t  state_d;    // next phase
	logic [8:0]  timer_q;    // pulse timer
	logic [8:0]  timer_d;    // next pulse timer
	logic [1:0]  car_q;      // carrier phase
	logic [1:0]  car_d;      // next carrier phase
	logic [7:0]  cur_val;    // addressed register value
	logic [7:0]  new_val;    // value to store back
	logic        do_store;   // write, and or or request
	logic        cnt_load;   // burst start by low byte store
	logic        burst_end;  // counter reaches zero
	logic        rint_hit;   // interrupt clear strobe
	logic        pwm_en;     // continuous train mode
	logic        lgp_en;     // long_pulse_enable
	logic        hf_en;      // carrier_modulate_enable
	logic        out_act_d;  // output active next cycle
	logic [9:0]  cnt_dec;    // counter minus one

	assign pwm_en = ctrl_q[IRM_CTRL_PWM_BIT];
	assign lgp_en = ctrl_q[IRM_CTRL_LGP_BIT];
	assign hf_en  = ctrl_q[IRM_CTRL_HF_BIT];

	// current value of the addressed register, unmapped reads zero
	always_comb
	begin
		cur_val = 8'h00;
		unique case (req.addr)
			IRM_ADDR_ON_LEN:   cur_val = on_len_q;
			IRM_ADDR_OFF_LEN:  cur_val = off_len_q;
			IRM_ADDR_CNT_LOW:  cur_val = cnt_q[IRM_CNT_LW-1:0];
			IRM_ADDR_CTRL:     cur_val = {5'h00, ctrl_q}; // reserved and strobes read zero
			IRM_ADDR_CNT_HIGH: cur_val = {6'h00, cnt_q[IRM_CNT_W-1:IRM_CNT_LW]};
			default:           cur_val = 8'h00; // addresses 5 to 7 unmapped
		endcase
	end

	// combine accumulator with register for the four operations
	always_comb
	begin
		new_val  = req.data;
		do_store = req.valid;
		unique case (req.op)
			IRM_OP_WRITE: new_val = req.data;
			IRM_OP_READ:
			begin
				new_val  = cur_val;
				do_store = 1'b0; // read stores nothing
			end
			IRM_OP_AND:   new_val = cur_val & req.data;
			IRM_OP_OR:    new_val = cur_val | req.data;
		endcase
	end

	assign cnt_load = do_store && (req.addr == IRM_ADDR_CNT_LOW);
	assign rint_hit = do_store && (req.addr == IRM_ADDR_CTRL) && new_val[IRM_CTRL_RINT_BIT];
	assign cnt_dec  = cnt_q - 10'h001;

	// read data register
	always_ff @(posedge core_clk or negedge nrst)
	begin
		if (!nrst)
			rdata <= 8'h00;
		else if (req.valid && (req.op == IRM_OP_READ))
			rdata <= cur_val;
	end

	// timing registers, retained across bursts
	always_ff @(posedge core_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			on_len_q  <= IRM_RST_ON_LEN;
			off_len_q <= IRM_RST_OFF_LEN;
		end
		else
		begin
			if (do_store && (req.addr == IRM_ADDR_ON_LEN))
				on_len_q <= new_val;
			if (do_store && (req.addr == IRM_ADDR_OFF_LEN))
				off_len_q <= new_val;
		end
	end

	// stored control bits; strobe bits are not kept
	always_ff @(posedge core_clk or negedge nrst)
	begin
		if (!nrst)
			ctrl_q <= IRM_RST_CTRL;
		else if (do_store && (req.addr == IRM_ADDR_CTRL))
			ctrl_q <= new_val[2:0];
	end

	// watchdog reload strobe, one cycle
	always_ff @(posedge core_clk or negedge nrst)
	begin
		if (!nrst)
			wdt_clear <= 1'b0;
		else
			wdt_clear <= do_store && (req.addr == IRM_ADDR_CTRL)
				&& new_val[IRM_CTRL_WDT_BIT];
	end

	// phase sequencer, pulse timer and pulse counter next values
	always_comb
	begin
		state_d   = state_q;
		timer_d   = timer_q;
		cnt_d     = cnt_q;
		burst_end = 1'b0;
		unique case (state_q)
			IRM_ST_IDLE: ; // wait for a counter load
			IRM_ST_ON:
			begin
				if (timer_q != 9'h000)
					timer_d = timer_q - 9'h001; // count down each cycle
				else if (pwm_en)
				begin
					// endless train, counter untouched
					if (lgp_en)
						timer_d = {1'b0, on_len_q} + IRM_TIMER_BIAS;
					else
					begin
						state_d = IRM_ST_OFF;
						timer_d = {1'b0, off_len_q} + IRM_TIMER_BIAS;
					end
				end
				else
				begin
					cnt_d = cnt_dec;
					if (cnt_dec == 10'h000)
					begin
						state_d   = IRM_ST_IDLE;
						burst_end = 1'b1;
					end
					else if (lgp_en)
						timer_d = {1'b0, on_len_q} + IRM_TIMER_BIAS;
					else
					begin
						state_d = IRM_ST_OFF;
						timer_d = {1'b0, off_len_q} + IRM_TIMER_BIAS;
					end
				end
			end
			IRM_ST_OFF:
			begin
				if (timer_q != 9'h000)
					timer_d = timer_q - 9'h001;
				else
				begin
					state_d = IRM_ST_ON;
					timer_d = {1'b0, on_len_q} + IRM_TIMER_BIAS;
				end
			end
			default:
			begin
				state_d = IRM_ST_IDLE; // illegal code recovers
			end
		endcase
		// a counter store overrides the sequencer
		if (do_store && (req.addr == IRM_ADDR_CNT_HIGH))
			cnt_d = {new_val[1:0], cnt_d[IRM_CNT_LW-1:0]};
		if (cnt_load)
		begin
			cnt_d     = {cnt_q[IRM_CNT_W-1:IRM_CNT_LW], new_val};
			state_d   = IRM_ST_ON;
			timer_d   = {1'b0, on_len_q} + IRM_TIMER_BIAS;
			burst_end = 1'b0;
		end
	end

	// sequencer registers
	always_ff @(posedge core_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			state_q <= IRM_ST_IDLE;
			timer_q <= 9'h000;
			cnt_q   <= IRM_RST_CNT;
		end
		else
		begin
			state_q <= state_d;
			timer_q <= timer_d;
			cnt_q   <= cnt_d;
		end
	end

	// carrier phase restarts when an on phase is entered
	always_comb
	begin
		car_d = car_q + 2'h1;
		if ((state_d == IRM_ST_ON) && ((state_q != IRM_ST_ON) || cnt_load))
			car_d = IRM_CAR_RST;
		out_act_d = (state_d == IRM_ST_ON) && (!hf_en || !car_d[1]);
	end

	// carrier counter and output pin, registered
	always_ff @(posedge core_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			car_q     <= IRM_CAR_RST;
			mod_out_n <= 1'b1;
		end
		else
		begin
			car_q     <= car_d;
			mod_out_n <= !out_act_d;
		end
	end

	// interrupt flip-flop, setting wins over a direct clear
	always_ff @(posedge core_clk or negedge nrst)
	begin
		if (!nrst)
			mod_irq <= 1'b0;
		else if (burst_end)
			mod_irq <= 1'b1;
		else if (cnt_load)
			mod_irq <= 1'b0;
		else if (rint_hit)
			mod_irq <= 1'b0;
	end

	// port latches with their reset levels
	always_ff @(posedge core_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			port0 <= IRM_RST_PORT0;
			port1 <= IRM_RST_PORT1;
			port2 <= IRM_RST_PORT2;
		end
		else
		begin
			if (port_we[0])
				port0 <= port_wdata;
			if (port_we[1])
				port1 <= port_wdata;
			if (port_we[2])
				port2 <= port_wdata[3:0];
		end
	end

endmodule : irm_modulator
`default_nettype wire

// ### irm_monitor.sv
// assertion checker bound to the pulse-burst modulator ports
`timescale 1ns/1ps
`default_nettype none
module irm_monitor
(
	input wire logic              core_clk,  // clock
	input wire logic              nrst,      // reset, active low
	input wire irm_pkg::irm_req_t req,       // register request
	input wire logic [7:0]        rdata,     // read data
	input wire logic              mod_out_n, // pin, active low
	input wire logic              mod_irq,   // interrupt flip-flop
	input wire logic              wdt_clear  // watchdog strobe
);
	import irm_pkg::*;
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!nrst);
	// plain write to the control register
	wire logic cw = req.valid && req.op == IRM_OP_WRITE && req.addr == IRM_ADDR_CTRL;
	// read request
	wire logic rq = req.valid && req.op == IRM_OP_READ;
	property p_wdt; cw && req.data[4] |=> wdt_clear; endproperty
	a_wdt: assert property (p_wdt) else $error("no watchdog strobe");
	property p_wsrc; wdt_clear |-> $past(req.valid) && $past(req.addr) == IRM_ADDR_CTRL; endproperty
	a_wsrc: assert property (p_wsrc) else $error("stray watchdog strobe");
	property p_rint; cw && req.data[3] && mod_out_n |=> !mod_irq; endproperty
	a_rint: assert property (p_rint) else $error("interrupt not cleared");
	property p_load; req.valid && req.op == IRM_OP_WRITE && req.addr == IRM_ADDR_CNT_LOW
		|=> !mod_irq && !mod_out_n; endproperty
	a_load: assert property (p_load) else $error("count load did not start");
	property p_irq; $rose(mod_irq) |-> mod_out_n; endproperty
	a_irq: assert property (p_irq) else $error("interrupt while active");
	property p_on; $fell(mod_out_n) |=> !mod_out_n; endproperty
	a_on: assert property (p_on) else $error("active run too short");
	property p_off; $rose(mod_out_n) && !mod_irq && !req.valid |=> mod_out_n; endproperty
	a_off: assert property (p_off) else $error("idle run too short");
	property p_rd; $changed(rdata) |-> $past(rq); endproperty
	a_rd: assert property (p_rd) else $error("read data moved");
	property p_unm; rq && req.addr > IRM_ADDR_CNT_HIGH |=> rdata == 8'h00; endproperty
	a_unm: assert property (p_unm) else $error("unmapped read not zero");
	property p_ctl; rq && req.addr == IRM_ADDR_CTRL |=> rdata[7:3] == 5'h00; endproperty
	a_ctl: assert property (p_ctl) else $error("control upper bits set");
endmodule : irm_monitor
bind irm_modulator irm_monitor irm_monitor_i (.core_clk(core_clk), .nrst(nrst), .req(req),
	.rdata(rdata), .mod_out_n(mod_out_n), .mod_irq(mod_irq), .wdt_clear(wdt_clear));
`default_nettype wire

// ### irm_ir_led.sv
// transistor and led model: measures each lit run of the pin
`timescale 1ns/1ps
`default_nettype none
module irm_ir_led
(
	input  wire logic        core_clk,  // clock
	input  wire logic        nrst,      // reset, active low
	input  wire logic        mod_out_n, // led lit while low
	output var  logic        lit_done,  // one pulse after each lit run
	output var  logic [15:0] lit_len    // lit count one cycle late; last run length while lit_done is high
);
	logic [15:0] cnt_q; // lit cycles so far
	// count lit cycles, report when the pin lets go
	always_ff @(posedge core_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			cnt_q    <= 16'h0000;
			lit_done <= 1'b0;
			lit_len  <= 16'h0000;
		end
		else
		begin
			cnt_q    <= mod_out_n ? 16'h0000 : cnt_q + 16'h0001;
			lit_done <= mod_out_n && cnt_q != 16'h0000;
			lit_len  <= cnt_q;
		end
	end
endmodule : irm_ir_led
`default_nettype wire

// ### irm_modulator_tb.sv
// self-checking bench for the pulse-burst modulator
`timescale 1ns/1ps
`default_nettype none
module irm_modulator_tb;
	import irm_pkg::*;
	logic core_clk = 1'b0;
	logic nrst = 1'b0;
	irm_req_t req = '0;
	logic [7:0] rdata, port0, port1, on, off;
	logic [3:0] port2;
	logic [9:0] n;
	logic mod_out_n, mod_irq, wdt_clear, lit_done;
	logic rd_pend = 1'b0;
	logic [15:0] lit_len;
	logic [15:0] rq[$], pq[$]; // expected reads and lit runs
	int err_count = 0, tests_run = 0, cnt;
	always #5 core_clk = ~core_clk;
	irm_modulator irm_modulator_i (.core_clk(core_clk), .nrst(nrst), .req(req), .port_we(3'h0),
		.port_wdata(8'h00), .rdata(rdata), .mod_out_n(mod_out_n), .mod_irq(mod_irq),
		.wdt_clear(wdt_clear), .port0(port0), .port1(port1), .port2(port2));
	irm_ir_led irm_ir_led_i (.core_clk(core_clk), .nrst(nrst), .mod_out_n(mod_out_n),
		.lit_done(lit_done), .lit_len(lit_len));
	task chk(input logic [15:0] seen, input logic [15:0] exp);
		tests_run++;
		if (seen !== exp)
		begin
			err_count++;
			$display("[ERR] %0t got %h want %h", $time, seen, exp);
		end
	endtask : chk
	task results;
		$display("checks %0d errors %0d", tests_run, err_count);
		if (err_count == 0 && tests_run > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask : results
	task op(input irm_op_t o, input logic [2:0] a, input logic [7:0] d);
		@(posedge core_clk) req <= {1'b1, o, a, d};
		@(posedge core_clk) req.valid <= 1'b0;
	endtask : op
	task rd(input logic [2:0] a, input logic [7:0] e);
		rq.push_back({8'h00, e});
		op(IRM_OP_READ, a, 8'h00);
	endtask : rd
	// program a burst, note its lit runs, time it up to the interrupt
	task burst(input logic [2:0] m, input int runs, input int len, input int wt);
		op(IRM_OP_WRITE, IRM_ADDR_ON_LEN, on);
		op(IRM_OP_WRITE, IRM_ADDR_OFF_LEN, off);
		op(IRM_OP_WRITE, IRM_ADDR_CTRL, {5'h00, m});
		op(IRM_OP_WRITE, IRM_ADDR_CNT_HIGH, {6'h00, n[9:8]});
		repeat (runs) pq.push_back(16'(len));
		op(IRM_OP_WRITE, IRM_ADDR_CNT_LOW, n[7:0]);
		cnt = 1;
		@(negedge core_clk);
		// count cycles from the count load until the interrupt
		while (mod_irq !== 1'b1 && cnt < 5000)
		begin
			cnt++;
			@(negedge core_clk);
		end
		chk(16'(cnt - 1), 16'(wt));
		rd(IRM_ADDR_CNT_LOW, 8'h00);
		rd(IRM_ADDR_ON_LEN, on);
	endtask : burst
	// read data and lit runs are compared as they show up
	always @(negedge core_clk)
	begin
		if (rd_pend) chk(rdata, rq.pop_front());
		rd_pend = req.valid && req.op == IRM_OP_READ;
		if (lit_done === 1'b1) chk(lit_len, pq.size() ? pq.pop_front() : 16'hFFFF);
	end
	initial
	begin
		void'($urandom(32'h5213));
		repeat (6) @(posedge core_clk);
		nrst <= 1'b1;
		@(negedge core_clk);
		chk({port0, port1}, 16'h00FF);
		chk({11'h000, mod_out_n, port2}, 16'h001F);
		rd(IRM_ADDR_OFF_LEN, IRM_RST_OFF_LEN);
		op(IRM_OP_WRITE, IRM_ADDR_ON_LEN, 8'hA5);
		rd(IRM_ADDR_ON_LEN, 8'hA5);
		op(IRM_OP_AND, IRM_ADDR_ON_LEN, 8'h0F);
		rd(IRM_ADDR_ON_LEN, 8'h05);
		op(IRM_OP_OR, IRM_ADDR_ON_LEN, 8'h30);
		rd(IRM_ADDR_ON_LEN, 8'h35);
		op(IRM_OP_WRITE, IRM_ADDR_CTRL, 8'hFF);
		rd(IRM_ADDR_CTRL, 8'h07);
		op(IRM_OP_WRITE, 3'h5, 8'hFF);
		rd(3'h5, 8'h00);
		op(IRM_OP_WRITE, IRM_ADDR_CNT_HIGH, 8'h03);
		rd(IRM_ADDR_CNT_HIGH, 8'h03);
		$display("registers done");
		repeat (4)
		begin
			on = 8'($urandom % 6);
			off = 8'($urandom % 6);
			n = 10'(1 + $urandom % 4);
			burst(3'h0, n, on + 2, n * (on + 2) + (n - 1) * (off + 2));
		end
		on = 8'h00;
		off = 8'h00;
		n = 10'h101;
		burst(3'h0, 257, 2, 1026);
		on = 8'h03;
		n = 10'h005;
		burst(3'h2, 1, 25, 25);
		// long pulse with carrier: carrier keeps running across reloads
		on = 8'h02;
		n = 10'h002;
		burst(3'h3, 2, 2, 8);
		// two pulses: carrier must restart low at the second on phase
		on = 8'h06;
		n = 10'h002;
		burst(3'h1, 4, 2, 18);
		$display("bursts done");
		op(IRM_OP_WRITE, IRM_ADDR_CTRL, 8'h08);
		@(negedge core_clk);
		chk({15'h0000, mod_irq}, 16'h0000);
		op(IRM_OP_WRITE, IRM_ADDR_ON_LEN, 8'h01);
		op(IRM_OP_WRITE, IRM_ADDR_OFF_LEN, 8'h01);
		op(IRM_OP_WRITE, IRM_ADDR_CTRL, 8'h04);
		repeat (4) pq.push_back(16'h0003);
		op(IRM_OP_WRITE, IRM_ADDR_CNT_LOW, 8'h01);
		cnt = 0;
		while (pq.size() != 0 && cnt < 200)
		begin
			cnt++;
			@(negedge core_clk);
		end
		chk(16'(pq.size()), 16'h0000);
		chk({15'h0000, mod_irq}, 16'h0000);
		// reset in mid-train, driven on the rising edge
		@(posedge core_clk) nrst <= 1'b0;
		@(negedge core_clk);
		chk({15'h0000, mod_out_n}, 16'h0001);
		chk({port0, port1}, 16'h00FF);
		@(posedge core_clk) nrst <= 1'b1;
		rd(IRM_ADDR_ON_LEN, IRM_RST_ON_LEN);
		rd(IRM_ADDR_CTRL, {5'h00, IRM_RST_CTRL});
		repeat (2) @(negedge core_clk);
		$display("modes done");
		results();
	end
	// watchdog: the tests need well under two thousand cycles
	initial
	begin
		#100000;
		err_count++;
		results();
	end
endmodule : irm_modulator_tb
`default_nettype wire
